// ===== hw/capgpi_regs.sv
//----------------------------------------------------------------------
// Caption GPI and output control register bank
//----------------------------------------------------------------------
// Purpose : Two-channel control registers for caption miscellaneous
//           functions, regeneration bypass and virtual GPI mapping,
//           plus the control levels they steer
// Assumes : Classic Wishbone slave, one clock, synchronous reset
// Notes   : Byte address is register index times four; data in bits 7:0
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/100ps

module capgpi_regs
    import capgpi_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES = IDLE_CYCLES_DEF
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // External general purpose inputs, shared by both channels
    input  wire logic [3:0]  ext_gpi_i,
    // Per channel inputs, bit 0 channel A, bit 1 channel B
    input  wire logic [1:0]  caption_activity_i,
    input  wire logic [1:0]  received_stream_input_flag_i,
    // Per channel controls
    output logic      [1:0]  apology_show_o,
    output logic      [1:0]  filler_insert_en_o,
    output logic      [1:0]  transmitted_stream_input_flag_o,
    output logic      [7:0]  video_outputs_burn_o,
    output logic      [1:0]  packet31_regen_only_o,
    output logic      [1:0]  caption_clear_o,
    output logic      [1:0]  regen_bypass_active_o,
    output logic      [1:0]  subtitle_blank_o
);

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    typedef struct packed {
        capgpi_regs_s     [NCHAN-1:0] regs;
        capgpi_chan_out_s [NCHAN-1:0] outs;
        logic                         ack;
        logic [7:0]                   rdat;
    } capgpi_state_s;

    capgpi_state_s st_reg;
    capgpi_state_s st_next;

    logic [NCHAN-1:0] idle_expired;

    //------------------------------------------------------------------
    // Idle timers, one per channel
    //------------------------------------------------------------------
    genvar gc;
    generate
        for (gc = 0; gc < NCHAN; gc++) begin : g_idle
            capgpi_idle_timer #(
                .IDLE_CYCLES (IDLE_CYCLES)
            ) u_idle (
                .clk_i      (clk_i),
                .rst_i      (rst_i),
                .activity_i (caption_activity_i[gc]),
                .expired_o  (idle_expired[gc])
            );
        end
    endgenerate

    //------------------------------------------------------------------
    // Bus decode
    //------------------------------------------------------------------
    logic [IDX_W-1:0] idx;
    logic             req;
    logic             wr_en;

    // New request only while no ack is standing
    assign idx   = wb_adr_i[ADR_LO +: IDX_W];
    assign req   = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    assign wr_en = req & wb_we_i & wb_sel_i[0];

    //------------------------------------------------------------------
    // Status byte: channel A in 3:0, channel B in 7:4
    //------------------------------------------------------------------
    logic [7:0] status;

    always_comb begin
        status = '0;
        for (int c = 0; c < NCHAN; c++) begin
            status[4*c]   = st_reg.outs[c].apology_show;
            status[4*c+1] = st_reg.outs[c].tx_flag;
            status[4*c+2] = st_reg.outs[c].subtitle_blank;
            status[4*c+3] = idle_expired[c];
        end
    end

    //------------------------------------------------------------------
    // Read multiplexer
    //------------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        unique case (idx)
            IDX_STATUS:   rd_mux = status;
            IDX_MISC_A:   rd_mux = st_reg.regs[0].misc;
            IDX_BYPASS_A: rd_mux = st_reg.regs[0].bypass;
            IDX_MAP_A:    rd_mux = st_reg.regs[0].vmap;
            IDX_MISC_B:   rd_mux = st_reg.regs[1].misc;
            IDX_BYPASS_B: rd_mux = st_reg.regs[1].bypass;
            IDX_MAP_B:    rd_mux = st_reg.regs[1].vmap;
            default:      rd_mux = '0;
        endcase
    end

    //------------------------------------------------------------------
    // Virtual input resolution per channel
    //------------------------------------------------------------------
    logic [NCHAN-1:0][NVIRT-1:0] vgpi;
    logic [NCHAN-1:0]            byp_gpi;

    // Each 2-bit field picks one external input, virtual 1 lowest
    always_comb begin
        for (int c = 0; c < NCHAN; c++) begin
            for (int v = 0; v < NVIRT; v++) begin
                vgpi[c][v] = ext_gpi_i[
                    st_reg.regs[c].vmap[MAP_FLD_W*v +: MAP_FLD_W]];
            end
            byp_gpi[c] = ext_gpi_i[
                st_reg.regs[c].bypass[BYP_SEL_HI:BYP_SEL_LO]];
        end
    end

    //------------------------------------------------------------------
    // Next state
    //------------------------------------------------------------------
    always_comb begin
        logic [7:0]   m;
        logic [7:0]   b;
        capgpi_vout_e mode;
        m       = '0;
        b       = '0;
        mode    = CAPGPI_VOUT_NORMAL;
        st_next = st_reg;

        // Answer every request one cycle later, then drop ack
        st_next.ack  = req;
        st_next.rdat = req ? rd_mux : st_reg.rdat;

        // Register writes; status and unmapped indices ignore writes
        if (wr_en) begin
            unique case (idx)
                IDX_MISC_A:   st_next.regs[0].misc   = wb_dat_i[7:0];
                IDX_BYPASS_A: st_next.regs[0].bypass = wb_dat_i[7:0];
                IDX_MAP_A:    st_next.regs[0].vmap   = wb_dat_i[7:0];
                IDX_MISC_B:   st_next.regs[1].misc   = wb_dat_i[7:0];
                IDX_BYPASS_B: st_next.regs[1].bypass = wb_dat_i[7:0];
                IDX_MAP_B:    st_next.regs[1].vmap   = wb_dat_i[7:0];
                default:      ;
            endcase
        end

        // Channel controls, each from its own register copy
        for (int c = 0; c < NCHAN; c++) begin
            m    = st_reg.regs[c].misc;
            b    = st_reg.regs[c].bypass;
            mode = capgpi_vout_e'(m[MISC_VOUT_HI:MISC_VOUT_LO]);

            // Apology message: idle time or forcing input
            st_next.outs[c].apology_show =
                (~m[MISC_APOL_DIS] & idle_expired[c])
                | (~m[MISC_FAPO_DIS] & vgpi[c][VIN_FAPO]);

            // Burst to continuous conversion
            st_next.outs[c].filler_en = m[MISC_FILL_EN];

            // Transmitted flag source
            if (m[MISC_TX_OR]) begin
                st_next.outs[c].tx_flag = vgpi[c][VIN_TX]
                    | received_stream_input_flag_i[c];
            end else begin
                st_next.outs[c].tx_flag = vgpi[c][VIN_TX];
            end

            // Output routing; a set burn bit is a monitoring output
            unique case (mode)
                CAPGPI_VOUT_NORMAL:
                    st_next.outs[c].burn = BURN_NORMAL;
                CAPGPI_VOUT_MONITOR:
                    st_next.outs[c].burn = BURN_ALL;
                CAPGPI_VOUT_CLEAN:
                    st_next.outs[c].burn = BURN_NONE;
                default:
                    st_next.outs[c].burn = BURN_NORMAL;
            endcase

            // Row 31 only regeneration from its assigned input
            st_next.outs[c].p31_only =
                ~m[MISC_P31_DIS] & vgpi[c][VIN_P31];

            // Forced caption clear from its assigned input
            st_next.outs[c].caption_clear =
                ~m[MISC_CLR_DIS] & vgpi[c][VIN_CLR];

            // Bypass: while enabled, a high input blanks subtitles
            st_next.outs[c].bypass_active  = b[BYP_EN];
            st_next.outs[c].subtitle_blank = b[BYP_EN] & byp_gpi[c];
        end
    end

    //------------------------------------------------------------------
    // State register
    //------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            for (int c = 0; c < NCHAN; c++) begin
                st_reg.regs[c].misc     <= RST_MISC;
                st_reg.regs[c].bypass   <= RST_BYPASS;
                st_reg.regs[c].vmap     <= RST_MAP;
                st_reg.outs[c].burn     <= BURN_NORMAL;
            end
        end else begin
            st_reg <= st_next;
        end
    end

    //------------------------------------------------------------------
    // Outputs, all straight from the state register
    //------------------------------------------------------------------
    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = {24'h0, st_reg.rdat};

    generate
        for (gc = 0; gc < NCHAN; gc++) begin : g_out
            assign apology_show_o[gc]        = st_reg.outs[gc].apology_show;
            assign filler_insert_en_o[gc]    = st_reg.outs[gc].filler_en;
            assign transmitted_stream_input_flag_o[gc] =
                st_reg.outs[gc].tx_flag;
            assign video_outputs_burn_o[NOUT*gc +: NOUT] =
                st_reg.outs[gc].burn;
            assign packet31_regen_only_o[gc] = st_reg.outs[gc].p31_only;
            assign caption_clear_o[gc]       = st_reg.outs[gc].caption_clear;
            assign regen_bypass_active_o[gc] = st_reg.outs[gc].bypass_active;
            assign subtitle_blank_o[gc]      = st_reg.outs[gc].subtitle_blank;
        end
    endgenerate

endmodule // capgpi_regs

// ===== pkg/capgpi_pkg.sv
//----------------------------------------------------------------------
// Caption GPI and output control register package
//----------------------------------------------------------------------
// Purpose : Offsets, field positions, reset values, timing and carriers
//           for the two-channel caption GPI control register bank
// Assumes : 125 MHz clock, classic Wishbone slave with 32-bit data
// Notes   : Register index times four is the byte address
//
// Notes on behaviour
// - Misc bit 7 low shows the apology message after 10 s idle, high stops it.
// - Misc bit 6 high enables time filler insertion, turning bursts continuous.
// - Misc bit 5 low takes the transmitted flag only from its mapped input.
// - Misc bit 5 high ORs the mapped input with the received stream flag.
// - Misc bits 4:3 pick routing: 00 normal, 01 all monitor, 10 all clean.
// - Normal routing makes outputs 3 and 4 monitoring, outputs 1 and 2 clean.
// - A monitoring output has burnt-in captions, a clean output has none.
// - Misc bit 2 low lets an assigned input force the apology message.
// - Misc bit 1 low lets an assigned input select row 31 only regeneration.
// - Misc bit 0 low lets an assigned input force a caption clear.
// - The bypass register assigns one external input per channel to bypass.
// - While bypass is active the input level picks regenerate or blank.
// - The mapping register holds four 2-bit external input picks, low first.

package capgpi_pkg;

    //------------------------------------------------------------------
    // Register indices
    //------------------------------------------------------------------
    localparam int          IDX_W         = 6;
    localparam logic [5:0]  IDX_STATUS    = 6'h01;
    localparam logic [5:0]  IDX_MISC_A    = 6'h10;
    localparam logic [5:0]  IDX_BYPASS_A  = 6'h11;
    localparam logic [5:0]  IDX_MAP_A     = 6'h13;
    localparam logic [5:0]  IDX_MISC_B    = 6'h30;
    localparam logic [5:0]  IDX_BYPASS_B  = 6'h31;
    localparam logic [5:0]  IDX_MAP_B     = 6'h33;
    localparam int          ADR_LO        = 2;
    localparam int          NCHAN         = 2;

    //------------------------------------------------------------------
    // Reset values
    //------------------------------------------------------------------
    localparam logic [7:0]  RST_MISC      = 8'h80;
    localparam logic [7:0]  RST_BYPASS    = 8'h00;
    localparam logic [7:0]  RST_MAP       = 8'he4;

    //------------------------------------------------------------------
    // Field positions
    //------------------------------------------------------------------
    localparam int          MISC_APOL_DIS = 7;
    localparam int          MISC_FILL_EN  = 6;
    localparam int          MISC_TX_OR    = 5;
    localparam int          MISC_VOUT_HI  = 4;
    localparam int          MISC_VOUT_LO  = 3;
    localparam int          MISC_FAPO_DIS = 2;
    localparam int          MISC_P31_DIS  = 1;
    localparam int          MISC_CLR_DIS  = 0;
    localparam int          BYP_SEL_HI    = 1;
    localparam int          BYP_SEL_LO    = 0;
    localparam int          BYP_EN        = 2;
    localparam int          MAP_FLD_W     = 2;
    localparam int          NVIRT         = 4;
    localparam int          NOUT          = 4;
    // Virtual input roles
    localparam int          VIN_TX        = 0;
    localparam int          VIN_FAPO      = 1;
    localparam int          VIN_P31       = 2;
    localparam int          VIN_CLR       = 3;

    //------------------------------------------------------------------
    // Video routing
    //------------------------------------------------------------------
    typedef enum logic [1:0] {
        CAPGPI_VOUT_NORMAL  = 2'h0,
        CAPGPI_VOUT_MONITOR = 2'h1,
        CAPGPI_VOUT_CLEAN   = 2'h2,
        CAPGPI_VOUT_UNUSED  = 2'h3
    } capgpi_vout_e;
    // Burn mask per output, bit n is output n+1; set means burnt-in
    localparam logic [3:0]  BURN_NORMAL   = 4'hc;
    localparam logic [3:0]  BURN_ALL      = 4'hf;
    localparam logic [3:0]  BURN_NONE     = 4'h0;

    //------------------------------------------------------------------
    // Timing
    //------------------------------------------------------------------
    localparam int unsigned IDLE_TIME_MS  = 10000;
    localparam int unsigned CLK_FREQ_KHZ  = 125000;
    localparam int unsigned IDLE_CYCLES_DEF = IDLE_TIME_MS * CLK_FREQ_KHZ;

    //------------------------------------------------------------------
    // Carriers
    //------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] misc;
        logic [7:0] bypass;
        logic [7:0] vmap;
    } capgpi_regs_s;

    typedef struct packed {
        logic       apology_show;
        logic       filler_en;
        logic       tx_flag;
        logic [3:0] burn;
        logic       p31_only;
        logic       caption_clear;
        logic       bypass_active;
        logic       subtitle_blank;
    } capgpi_chan_out_s;

endpackage

// ===== hw/capgpi_idle_timer.sv
//----------------------------------------------------------------------
// Caption idle timer
//----------------------------------------------------------------------
// Purpose : Flags a channel that has seen no caption activity for a
//           programmable number of clock cycles
// Assumes : Activity is a level or pulse synchronous to clk_i
// Notes   : Counter saturates; any activity restarts it
`timescale 1ns/100ps

module capgpi_idle_timer
    import capgpi_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES = IDLE_CYCLES_DEF
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic activity_i,
    output logic      expired_o
);

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] cnt;
        logic        expired;
    } capgpi_tmr_s;

    localparam logic [31:0] LAST = 32'(IDLE_CYCLES - 1);

    capgpi_tmr_s st_reg;
    capgpi_tmr_s st_next;

    // Count idle cycles, clear on activity
    always_comb begin
        st_next = st_reg;
        if (activity_i) begin
            st_next.cnt     = '0;
            st_next.expired = 1'b0;
        end else if (st_reg.cnt >= LAST) begin
            st_next.expired = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 32'h1;
        end
    end

    // Register state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign expired_o = st_reg.expired;

endmodule // capgpi_idle_timer

// ===== bench/capgpi_regs_checker.sv
//----------------------------------------------------------------------
// Caption GPI register bank checker
//----------------------------------------------------------------------
// Purpose : Port-level assertions for the register bank
// Assumes : One clock, synchronous active-high reset
// Notes   : Bound into capgpi_regs
`timescale 1ns/100ps

module capgpi_regs_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [3:0]  ext_gpi_i,
    input wire logic [1:0]  received_stream_input_flag_i,
    input wire logic [1:0]  filler_insert_en_o,
    input wire logic [1:0]  transmitted_stream_input_flag_o,
    input wire logic [7:0]  video_outputs_burn_o,
    input wire logic [1:0]  packet31_regen_only_o,
    input wire logic [1:0]  caption_clear_o,
    input wire logic [1:0]  regen_bypass_active_o,
    input wire logic [1:0]  subtitle_blank_o
);
    default clocking dcb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    //------------------------------------------------------------------
    // Helper terms
    //------------------------------------------------------------------
    logic       taken;      // Request taken
    logic       wr_misc_a;
    logic       wr_misc_b;
    logic       gpi_any;    // Any input high
    logic [1:0] tx_src;     // Any tx source
    logic [3:0] burn_exp;   // Burn mask for written code
    // Decode taken writes and the sources an output may follow
    always_comb begin
        taken     = wb_cyc_i && wb_stb_i && !wb_ack_o;
        wr_misc_a = taken && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h40;
        wr_misc_b = taken && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'hc0;
        gpi_any   = |ext_gpi_i;
        tx_src    = {2{gpi_any}} | received_stream_input_flag_i;
        case (wb_dat_i[4:3])
            2'h1:    burn_exp = 4'hf;
            2'h2:    burn_exp = 4'h0;
            default: burn_exp = 4'hc;
        endcase
    end

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    a_ack_pulse_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answers_req: assert property (taken |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_rd_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_filler_follows_a: assert property (
        wr_misc_a |=> ##1 filler_insert_en_o[0] == $past(wb_dat_i[6], 2))
        else $error("filler A not following write");
    a_filler_follows_b: assert property (
        wr_misc_b |=> ##1 filler_insert_en_o[1] == $past(wb_dat_i[6], 2))
        else $error("filler B not following write");
    a_burn_route_a: assert property (
        wr_misc_a |=> ##1 video_outputs_burn_o[3:0] == $past(burn_exp, 2))
        else $error("burn A wrong for routing");
    a_burn_b_kept: assert property (
        wr_misc_a |=> ##1 $stable(video_outputs_burn_o[7:4]))
        else $error("burn B moved on A write");
    a_tx_has_source: assert property (
        (transmitted_stream_input_flag_o & ~$past(tx_src)) == 2'h0)
        else $error("tx flag with no source");
    a_clear_from_gpi: assert property (
        (|caption_clear_o) |-> $past(gpi_any))
        else $error("clear with no input high");
    a_row31_from_gpi: assert property (
        (|packet31_regen_only_o) |-> $past(gpi_any))
        else $error("row 31 with no input high");
    a_blank_needs_byp: assert property (
        (subtitle_blank_o & ~regen_bypass_active_o) == 2'h0)
        else $error("subtitle blank while bypass not enabled");
endmodule // capgpi_regs_checker

bind capgpi_regs capgpi_regs_checker u_chk (.*);

// ===== bench/tb_top.sv
//----------------------------------------------------------------------
// Caption GPI register bank testbench
//----------------------------------------------------------------------
// Purpose : Directed register and output tests
// Assumes : 125 MHz clock, short idle count for simulation
// Notes   : Inputs change by NBA at rising edges
`timescale 1ns/100ps

module tb_top;
    localparam int unsigned IDLE_T = 20;  // Shortened idle time
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  ext_gpi_i = 4'h0;
    logic [1:0]  caption_activity_i = 2'h0;
    logic [1:0]  received_stream_input_flag_i = 2'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [1:0]  apology_show_o, filler_insert_en_o, packet31_regen_only_o;
    logic [1:0]  transmitted_stream_input_flag_o, caption_clear_o;
    logic [1:0]  regen_bypass_active_o, subtitle_blank_o;
    logic [7:0]  video_outputs_burn_o;
    int          fails = 0;
    int          samples_checked = 0;
    logic [7:0]  ra [6] = '{8'h40, 8'h44, 8'h4c, 8'hc0, 8'hc4, 8'hcc};
    logic [7:0]  rv [6] = '{8'h80, 8'h00, 8'he4, 8'h80, 8'h00, 8'he4};
    logic [3:0]  bexp [4] = '{4'hc, 4'hf, 4'h0, 4'hc};
    logic [7:0]  tx_v, frc_v, byp_v, apo_v;

    // Output groups packed into bytes for the compares
    assign tx_v  = {6'h0, transmitted_stream_input_flag_o};
    assign frc_v = {2'h0, apology_show_o, packet31_regen_only_o,
                    caption_clear_o};
    assign byp_v = {4'h0, regen_bypass_active_o, subtitle_blank_o};
    assign apo_v = {6'h0, apology_show_o};

    capgpi_regs #(.IDLE_CYCLES(IDLE_T)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .ext_gpi_i(ext_gpi_i),
        .caption_activity_i(caption_activity_i),
        .received_stream_input_flag_i(received_stream_input_flag_i),
        .apology_show_o(apology_show_o),
        .filler_insert_en_o(filler_insert_en_o),
        .transmitted_stream_input_flag_o(transmitted_stream_input_flag_o),
        .video_outputs_burn_o(video_outputs_burn_o),
        .packet31_regen_only_o(packet31_regen_only_o),
        .caption_clear_o(caption_clear_o),
        .regen_bypass_active_o(regen_bypass_active_o),
        .subtitle_blank_o(subtitle_blank_o));

    // Clock generation
    always #4 clk_i = ~clk_i;

    //------------------------------------------------------------------
    // Bus, stimulus and compare tasks
    //------------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
        settle();
    endtask

    task automatic check_reg(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_out(input string what, input logic [7:0] exp,
                             input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 8'h0, q);
        check_reg("register read", {24'h0, exp}, q);
    endtask

    task automatic gpi(input logic [3:0] g, input logic [1:0] rx);
        @(posedge clk_i);
        ext_gpi_i <= g;
        received_stream_input_flag_i <= rx;
        settle();
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        tally_and_finish();
    end

    //------------------------------------------------------------------
    // Test sequence
    //------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        check_out("burn", 8'hcc, video_outputs_burn_o);
        for (int i = 0; i < 6; i++) rd_chk(ra[i], rv[i]);
        wr(8'h08, 8'h5a);
        rd_chk(8'h08, 8'h00);
        for (int i = 0; i < 3; i++) wr(ra[i], 8'h3c ^ 8'(i));
        for (int i = 0; i < 6; i++)
            rd_chk(ra[i], (i < 3) ? (8'h3c ^ 8'(i)) : rv[i]);
        for (int i = 0; i < 3; i++) wr(ra[i], rv[i]);
        for (int c = 0; c < 4; c++) begin
            wr(8'h40, 8'h80 | 8'(c << 3));
            check_out("burn", {4'hc, bexp[c]}, video_outputs_burn_o);
        end
        wr(8'hc0, 8'h88);
        check_out("burn", 8'hfc, video_outputs_burn_o);
        wr(8'hc0, 8'h80);
        wr(8'h40, 8'hc0);
        check_out("filler", 8'h01, {6'h0, filler_insert_en_o});
        wr(8'h40, 8'h80);
        check_out("filler", 8'h00, {6'h0, filler_insert_en_o});
        for (int k = 0; k < 4; k++) begin
            wr(8'h4c, {6'h39, 2'(k)});
            gpi(4'h1 << k, 2'h0);
            check_out("tx", {6'h0, k == 0, 1'b1}, tx_v);
            gpi(~(4'h1 << k), 2'h0);
            check_out("tx", {6'h0, k != 0, 1'b0}, tx_v);
        end
        wr(8'h4c, 8'he4);
        wr(8'h40, 8'ha0);
        gpi(4'h0, 2'h3);
        check_out("tx", 8'h01, tx_v);
        wr(8'h40, 8'h80);
        check_out("tx", 8'h00, tx_v);
        for (int j = 0; j < 3; j++) begin
            gpi(4'h2 << j, 2'h0);
            check_out("force", 8'h30 >> (2 * j), frc_v);
            wr(8'h40, 8'h87);
            check_out("force", 8'h20 >> (2 * j), frc_v);
            wr(8'h40, 8'h80);
        end
        wr(8'h40, 8'h87);
        wr(8'hc0, 8'h87);
        wr(8'h44, 8'h06);
        gpi(4'h4, 2'h0);
        check_out("bypass", 8'h05, byp_v);
        rd_chk(8'h04, 8'h8c);
        gpi(4'h0, 2'h0);
        check_out("bypass", 8'h04, byp_v);
        wr(8'h44, 8'h02);
        gpi(4'h4, 2'h0);
        check_out("bypass", 8'h00, byp_v);
        gpi(4'h0, 2'h0);
        wr(8'h40, 8'h00);
        check_out("apology", 8'h01, apo_v);
        @(posedge clk_i);
        caption_activity_i <= 2'h1;
        settle();
        check_out("apology", 8'h00, apo_v);
        @(posedge clk_i);
        caption_activity_i <= 2'h0;
        repeat (IDLE_T - 4) @(posedge clk_i);
        #1;
        check_out("apology", 8'h00, apo_v);
        repeat (8) @(posedge clk_i);
        #1;
        check_out("apology", 8'h01, apo_v);
        wr(8'h40, 8'h80);
        check_out("apology", 8'h00, apo_v);
        tally_and_finish();
    end
endmodule // tb_top
